// ==== core/two_wire_master.sv ====
// Master for the shared two-wire bus: START, packets, STOP, stretching, arbitration
`timescale 1ns/1ps
`default_nettype none

module two_wire_master
  import two_wire_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire two_wire_pkg::op_e cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  // Response port
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack,
  output logic rsp_arb_lost,
  output logic rsp_refused,
  // Bus state
  output logic bus_busy,
  output logic bus_owned,
  // Clock line pin
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  // Data line pin
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);

  typedef enum logic [3:0] {
    ST_READY, ST_WAIT_FREE, ST_START_HOLD, ST_RS_LOW, ST_RS_RISE, ST_RS_SETUP,
    ST_BIT_LOW, ST_BIT_RISE, ST_BIT_HIGH, ST_STOP_LOW, ST_STOP_RISE, ST_STOP_SETUP, ST_STOP_BUF
  } state_e;

  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic scl_f_q;
  logic sda_f_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic busy_q;
  state_e state_q;
  logic [15:0] timer_q;
  logic [8:0] shift_q;
  logic [7:0] rx_q;
  logic [3:0] bit_q;
  op_e op_q;
  logic rw_q;
  logic owned_q;
  logic data_seen_q;
  logic addr_nack_q;
  logic ready_q;
  logic rsp_valid_q;
  logic [7:0] rsp_data_q;
  logic rsp_nack_q;
  logic rsp_arb_lost_q;
  logic rsp_refused_q;
  logic scl_oe_n_q;
  logic sda_oe_n_q;
  logic scl_out_q;
  logic sda_out_q;

  // ----------------------------------------------------------------
  // Input synchronisers and filter
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scl_sync_q <= {3{LINE_IDLE_LEVEL}};
      sda_sync_q <= {3{LINE_IDLE_LEVEL}};
      scl_f_q <= LINE_IDLE_LEVEL;
      sda_f_q <= LINE_IDLE_LEVEL;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
      if (scl_sync_q[1] == scl_sync_q[2])
      begin
        scl_f_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2])
      begin
        sda_f_q <= sda_sync_q[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus busy monitor
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scl_prev_q <= LINE_IDLE_LEVEL;
      sda_prev_q <= LINE_IDLE_LEVEL;
      busy_q <= 1'b0;
    end
    else
    begin
      scl_prev_q <= scl_f_q;
      sda_prev_q <= sda_f_q;
      // A START, first or repeated, sets busy; only a STOP clears it
      if (scl_f_q && scl_prev_q && sda_prev_q && !sda_f_q)
      begin
        busy_q <= 1'b1;
      end
      else if (scl_f_q && scl_prev_q && !sda_prev_q && sda_f_q)
      begin
        busy_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ST_READY;
      timer_q <= TIMER_RESET;
      shift_q <= SHIFT_RESET;
      rx_q <= BYTE_RESET;
      bit_q <= FIRST_BIT_IDX;
      op_q <= OP_STOP;
      rw_q <= 1'b0;
      owned_q <= 1'b0;
      data_seen_q <= 1'b0;
      addr_nack_q <= 1'b0;
      ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= BYTE_RESET;
      rsp_nack_q <= 1'b0;
      rsp_arb_lost_q <= 1'b0;
      rsp_refused_q <= 1'b0;
      scl_oe_n_q <= LINE_RELEASED;
      sda_oe_n_q <= LINE_RELEASED;
    end
    else
    begin
      rsp_valid_q <= 1'b0;
      if (timer_q != TIMER_RESET)
      begin
        timer_q <= timer_q - 16'h0001;
      end
      case (state_q)
        ST_READY:
        begin
          ready_q <= 1'b1;
          if (cmd_valid && ready_q)
          begin
            ready_q <= 1'b0;
            rsp_nack_q <= 1'b0;
            rsp_arb_lost_q <= 1'b0;
            rsp_refused_q <= 1'b0;
            case (cmd_op)
              OP_ADDR:
              begin
                if ((cmd_data[7:1] == GENERAL_CALL_ADDR && cmd_data[0])
                    || cmd_data[7:4] == RESERVED_PREFIX)
                begin
                  rsp_refused_q <= 1'b1;
                  rsp_valid_q <= 1'b1;
                end
                else
                begin
                  shift_q <= {cmd_data, LINE_RELEASED};
                  rw_q <= cmd_data[0];
                  op_q <= OP_ADDR;
                  if (owned_q)
                  begin
                    timer_q <= LOW_CYC;
                    state_q <= ST_RS_LOW;
                  end
                  else
                  begin
                    state_q <= ST_WAIT_FREE;
                  end
                end
              end
              OP_WRITE, OP_READ:
              begin
                if (!owned_q || addr_nack_q || (rw_q != (cmd_op == OP_READ)))
                begin
                  rsp_refused_q <= 1'b1;
                  rsp_valid_q <= 1'b1;
                end
                else
                begin
                  // Reads release the eight data bits; the ninth is our ACK or NACK
                  shift_q <= (cmd_op == OP_READ) ? {8'hff, cmd_last}
                                                 : {cmd_data, LINE_RELEASED};
                  op_q <= cmd_op;
                  bit_q <= FIRST_BIT_IDX;
                  timer_q <= LOW_CYC;
                  state_q <= ST_BIT_LOW;
                end
              end
              default:
              begin
                if (!owned_q || !(data_seen_q || addr_nack_q))
                begin
                  rsp_refused_q <= 1'b1;
                  rsp_valid_q <= 1'b1;
                end
                else
                begin
                  op_q <= OP_STOP;
                  timer_q <= LOW_CYC;
                  state_q <= ST_STOP_LOW;
                end
              end
            endcase
          end
        end
        ST_WAIT_FREE:
        begin
          // Another master owns the bus until its STOP
          if (!busy_q && scl_f_q && sda_f_q)
          begin
            sda_oe_n_q <= 1'b0;
            owned_q <= 1'b1;
            timer_q <= HD_STA_CYC;
            state_q <= ST_START_HOLD;
          end
        end
        ST_RS_LOW:
        begin
          if (timer_q == DATA_CHANGE_AT)
          begin
            sda_oe_n_q <= LINE_RELEASED;
          end
          if (timer_q == TIMER_RESET)
          begin
            scl_oe_n_q <= LINE_RELEASED;
            state_q <= ST_RS_RISE;
          end
        end
        ST_RS_RISE:
        begin
          if (scl_f_q)
          begin
            timer_q <= SU_STA_CYC;
            state_q <= ST_RS_SETUP;
          end
        end
        ST_RS_SETUP:
        begin
          if (timer_q == TIMER_RESET)
          begin
            sda_oe_n_q <= 1'b0;
            timer_q <= HD_STA_CYC;
            state_q <= ST_START_HOLD;
          end
        end
        ST_START_HOLD:
        begin
          if (timer_q == TIMER_RESET)
          begin
            scl_oe_n_q <= 1'b0;
            bit_q <= FIRST_BIT_IDX;
            data_seen_q <= 1'b0;
            addr_nack_q <= 1'b0;
            timer_q <= LOW_CYC;
            state_q <= ST_BIT_LOW;
          end
        end
        ST_BIT_LOW:
        begin
          if (timer_q == DATA_CHANGE_AT)
          begin
            sda_oe_n_q <= shift_q[8];
          end
          if (timer_q == TIMER_RESET)
          begin
            scl_oe_n_q <= LINE_RELEASED;
            state_q <= ST_BIT_RISE;
          end
        end
        ST_BIT_RISE:
        begin
          // A slave may hold the clock low; wait for the line itself
          if (scl_f_q)
          begin
            timer_q <= HIGH_CYC;
            state_q <= ST_BIT_HIGH;
          end
        end
        ST_BIT_HIGH:
        begin
          if (timer_q == TIMER_RESET)
          begin
            if (bit_q != LAST_BIT_IDX && op_q != OP_READ && shift_q[8] && !sda_f_q)
            begin
              scl_oe_n_q <= LINE_RELEASED;
              sda_oe_n_q <= LINE_RELEASED;
              owned_q <= 1'b0;
              rsp_arb_lost_q <= 1'b1;
              rsp_valid_q <= 1'b1;
              state_q <= ST_READY;
            end
            else if (bit_q == LAST_BIT_IDX)
            begin
              scl_oe_n_q <= 1'b0;
              rsp_nack_q <= sda_f_q;
              rsp_data_q <= rx_q;
              rsp_valid_q <= 1'b1;
              if (op_q == OP_ADDR)
              begin
                addr_nack_q <= sda_f_q;
              end
              else
              begin
                data_seen_q <= 1'b1;
              end
              state_q <= ST_READY;
            end
            else
            begin
              scl_oe_n_q <= 1'b0;
              rx_q <= {rx_q[6:0], sda_f_q};
              shift_q <= {shift_q[7:0], LINE_RELEASED};
              bit_q <= bit_q + 4'h1;
              timer_q <= LOW_CYC;
              state_q <= ST_BIT_LOW;
            end
          end
        end
        ST_STOP_LOW:
        begin
          if (timer_q == DATA_CHANGE_AT)
          begin
            sda_oe_n_q <= 1'b0;
          end
          if (timer_q == TIMER_RESET)
          begin
            scl_oe_n_q <= LINE_RELEASED;
            state_q <= ST_STOP_RISE;
          end
        end
        ST_STOP_RISE:
        begin
          if (scl_f_q)
          begin
            timer_q <= SU_STO_CYC;
            state_q <= ST_STOP_SETUP;
          end
        end
        ST_STOP_SETUP:
        begin
          if (timer_q == TIMER_RESET)
          begin
            sda_oe_n_q <= LINE_RELEASED;
            timer_q <= BUF_CYC;
            state_q <= ST_STOP_BUF;
          end
        end
        default:
        begin
          if (timer_q == TIMER_RESET)
          begin
            owned_q <= 1'b0;
            data_seen_q <= 1'b0;
            addr_nack_q <= 1'b0;
            rsp_valid_q <= 1'b1;
            state_q <= ST_READY;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Open-drain drivers: the output level is always low
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scl_out_q <= 1'b0;
      sda_out_q <= 1'b0;
    end
    else
    begin
      scl_out_q <= 1'b0;
      sda_out_q <= 1'b0;
    end
  end

  assign cmd_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign rsp_nack = rsp_nack_q;
  assign rsp_arb_lost = rsp_arb_lost_q;
  assign rsp_refused = rsp_refused_q;
  assign bus_busy = busy_q;
  assign bus_owned = owned_q;
  assign scl_out = scl_out_q;
  assign scl_oe_n = scl_oe_n_q;
  assign sda_out = sda_out_q;
  assign sda_oe_n = sda_oe_n_q;

endmodule // two_wire_master

`default_nettype wire

// ==== core/two_wire_pkg.sv ====
// Constants and types shared by the two-wire bus master
package two_wire_pkg;

  // ----------------------------------------------------------------
  // Clock and bus timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_LOW_NS = 1300;
  localparam int T_HIGH_NS = 600;
  localparam int T_HD_DAT_NS = 300;
  localparam int T_SU_STA_NS = 600;
  localparam int T_HD_STA_NS = 600;
  localparam int T_SU_STO_NS = 600;
  localparam int T_BUF_NS = 1300;

  // Least times, rounded up to whole cycles
  localparam logic [15:0] LOW_CYC = 16'((T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] HIGH_CYC = 16'((T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] HD_DAT_CYC = 16'((T_HD_DAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] SU_STA_CYC = 16'((T_SU_STA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] HD_STA_CYC = 16'((T_HD_STA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] SU_STO_CYC = 16'((T_SU_STO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] BUF_CYC = 16'((T_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Timer value at which data changes inside the low phase
  localparam logic [15:0] DATA_CHANGE_AT = LOW_CYC - HD_DAT_CYC;
  localparam logic [15:0] TIMER_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Packet layout and addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] FIRST_BIT_IDX = 4'h0;
  localparam logic [3:0] LAST_BIT_IDX = 4'h8;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [3:0] RESERVED_PREFIX = 4'hf;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic LINE_RELEASED = 1'b1;
  localparam logic LINE_IDLE_LEVEL = 1'b1;
  localparam logic [8:0] SHIFT_RESET = 9'h1ff;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OP_ADDR, OP_WRITE, OP_READ, OP_STOP} op_e;

endpackage

// ==== tb/two_wire_master_sva.sv ====
// Concurrent checks on the ports of the two-wire bus master
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_sva
  import two_wire_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command and response
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire two_wire_pkg::op_e cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic rsp_valid,
  input wire logic rsp_arb_lost,
  input wire logic rsp_refused,
  // Bus state and pins
  input wire logic bus_busy,
  input wire logic bus_owned,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n
);
  import two_wire_pkg::*;
  logic [9:0] hi_cnt_q;
  logic [3:0] fall_cnt_q;
  op_e op_q;
  logic take;
  assign take = cmd_valid && cmd_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst || !scl_in)
      hi_cnt_q <= 10'h000;
    else if (hi_cnt_q != 10'h3ff)
      hi_cnt_q <= hi_cnt_q + 10'h001;
  end
  always_ff @(posedge clk)
  begin
    if (rst || take)
      fall_cnt_q <= 4'h0;
    else if ($fell(scl_oe_n))
      fall_cnt_q <= fall_cnt_q + 4'h1;
  end
  always_ff @(posedge clk)
  begin
    if (take)
      op_q <= cmd_op;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_pins_pull_low: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("bus pin driven high");
  a_start_sets_busy: assert property ($fell(sda_oe_n) && scl_in |-> ##[1:8] bus_busy)
    else $error("start did not mark bus busy");
  a_stop_clears_busy: assert property ($rose(sda_oe_n) && scl_in && bus_owned |-> ##[1:8] !bus_busy)
    else $error("stop did not free bus");
  a_busy_ends_stop: assert property ($fell(bus_busy) |-> $past(sda_in, 2) && $past(scl_in, 2))
    else $error("busy dropped without stop");
  a_refuse_gcall_read: assert property (take && cmd_op == OP_ADDR && cmd_data == 8'h01
    |-> ##[1:3] rsp_valid && rsp_refused)
    else $error("general call read not refused");
  a_refuse_reserved: assert property (take && cmd_op == OP_ADDR && cmd_data[7:4] == 4'hf
    |-> ##[1:3] rsp_valid && rsp_refused)
    else $error("reserved address not refused");
  a_arb_releases: assert property (rsp_valid && rsp_arb_lost |-> scl_oe_n && sda_oe_n && !bus_owned)
    else $error("lines kept after lost arbitration");
  a_high_phase: assert property ($fell(scl_oe_n) && hi_cnt_q < 10'd200
    |-> {6'h00, hi_cnt_q} >= HIGH_CYC && {6'h00, hi_cnt_q} <= HIGH_CYC + 16'd10)
    else $error("clock high phase length wrong");
  a_stretch_wait: assert property (scl_oe_n && !scl_in |=> scl_oe_n)
    else $error("clock pulled before line went high");
  a_packet_nine: assert property (rsp_valid && !rsp_refused && !rsp_arb_lost && op_q != OP_STOP
    |-> fall_cnt_q + 4'($fell(scl_oe_n)) == ((op_q == OP_ADDR) ? 4'ha : 4'h9))
    else $error("packet clock count wrong");
  c_stretch: cover property (scl_oe_n && !scl_in && bus_owned);
  c_arb: cover property (rsp_valid && rsp_arb_lost);
  c_refused: cover property (rsp_valid && rsp_refused);
endmodule // two_wire_master_sva
bind two_wire_master two_wire_master_sva two_wire_master_sva_i (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
  .rsp_arb_lost(rsp_arb_lost), .rsp_refused(rsp_refused), .bus_busy(bus_busy), .bus_owned(bus_owned),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n));
`default_nettype wire

// ==== tb/two_wire_slave_model.sv ====
// Behavioural slave on the two-wire bus: address match, ack, read data, stretching, contention
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_model #(
  parameter logic [6:0] OWN_ADDR = 7'h2a
) (
  // Wire levels
  input wire logic scl,
  input wire logic sda,
  // Behaviour controls
  input wire logic [7:0] tx_byte,
  input wire logic stretch_en,
  input wire logic contend,
  // Pins and received byte
  output logic scl_oe_n,
  output logic sda_oe_n,
  output logic [7:0] rx_byte
);
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  logic addr_ph = 1'b0;
  logic sel = 1'b0;
  logic rd = 1'b0;
  logic mnack = 1'b0;
  initial
  begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
    rx_byte = 8'h00;
  end
  // Start or repeated start opens an address packet
  always @(negedge sda)
  begin
    if (scl)
    begin
      cnt = 4'hf;
      addr_ph = 1'b1;
      mnack = 1'b0;
    end
  end
  always @(posedge sda)
  begin
    if (scl)
      sel = 1'b0;
  end
  always @(posedge scl)
  begin
    if (cnt < 4'h8)
      sh = {sh[6:0], sda};
    else if (cnt == 4'h8 && rd && !addr_ph)
      mnack = sda;
  end
  // Lines change only in the low phase, after a hold time
  always @(negedge scl)
  begin
    if (stretch_en)
    begin
      scl_oe_n <= 1'b0;
      scl_oe_n <= #2000 1'b1;
    end
    if (cnt == 4'h8)
      addr_ph = 1'b0;
    cnt = (cnt >= 4'h8) ? 4'h0 : cnt + 4'h1;
    if (cnt == 4'h8 && addr_ph)
    begin
      sel = (sh[7:1] == OWN_ADDR) || (sh == 8'h00);
      rd = sh[0];
    end
    if (cnt == 4'h8 && !addr_ph && !rd && sel)
      rx_byte = sh;
    sda_oe_n <= #50 !(cnt == 4'h8 ? sel && !(rd && !addr_ph) : (contend && addr_ph) ||
      (sel && rd && !addr_ph && !mnack && !tx_byte[3'(7 - cnt)]));
  end
endmodule // two_wire_slave_model
`default_nettype wire

// ==== tb/two_wire_master_tb.sv ====
// Self-checking bench for the two-wire master with a slave model on the bus
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[ERR] %s expected %h seen %h", what, exp, got); end end
module two_wire_master_tb;
  import two_wire_pkg::*;
  logic clk, rst, cmd_valid, cmd_last, stretch_en, contend;
  op_e cmd_op;
  logic [7:0] cmd_data, tx_byte, rx_byte, rsp_data;
  logic cmd_ready, rsp_valid, rsp_nack, rsp_arb_lost, rsp_refused, bus_busy, bus_owned;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, s_scl_oe_n, s_sda_oe_n;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  // Pull-up wired-AND of all parties
  wire logic scl = scl_oe_n & s_scl_oe_n;
  wire logic sda = sda_oe_n & s_sda_oe_n;
  two_wire_master two_wire_master_i (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_last(cmd_last), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_nack(rsp_nack), .rsp_arb_lost(rsp_arb_lost), .rsp_refused(rsp_refused), .bus_busy(bus_busy),
    .bus_owned(bus_owned), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  two_wire_slave_model two_wire_slave_model_i (.scl(scl), .sda(sda), .tx_byte(tx_byte),
    .stretch_en(stretch_en), .contend(contend), .scl_oe_n(s_scl_oe_n), .sda_oe_n(s_sda_oe_n),
    .rx_byte(rx_byte));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Offer a command, hold it until taken, then wait for its response
  task automatic do_cmd(input op_e op, input logic [7:0] d, input logic last);
    // Let an edge pass so valid never drops and rises in one time step
    @(posedge clk);
    #1;
    cmd_op = op;
    cmd_data = d;
    cmd_last = last;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic t_write();
    do_cmd(OP_ADDR, {7'h2a, 1'b0}, 1'b0);
    `CHK("addr ack", 1'b0, rsp_nack)
    `CHK("owned", 1'b1, bus_owned)
    `CHK("busy", 1'b1, bus_busy)
    do_cmd(OP_WRITE, 8'ha5, 1'b0);
    `CHK("write byte", 8'ha5, rx_byte)
    `CHK("write ack", 1'b0, rsp_nack)
    stretch_en = 1'b1;
    do_cmd(OP_WRITE, 8'h3c, 1'b0);
    `CHK("stretched byte", 8'h3c, rx_byte)
    stretch_en = 1'b0;
    do_cmd(OP_STOP, 8'h00, 1'b0);
    `CHK("stop busy", 1'b0, bus_busy)
    `CHK("stop owner", 1'b0, bus_owned)
    $display("t_write done");
  endtask
  task automatic t_read();
    tx_byte = 8'h96;
    do_cmd(OP_ADDR, {7'h2a, 1'b1}, 1'b0);
    `CHK("read addr ack", 1'b0, rsp_nack)
    do_cmd(OP_READ, 8'h00, 1'b0);
    `CHK("read byte", 8'h96, rsp_data)
    `CHK("read ack", 1'b0, rsp_nack)
    // Top bit of the next byte is already on the line, so keep it equal
    tx_byte = 8'hc3;
    do_cmd(OP_READ, 8'h00, 1'b1);
    `CHK("last byte", 8'hc3, rsp_data)
    `CHK("last nack", 1'b1, rsp_nack)
    do_cmd(OP_STOP, 8'h00, 1'b0);
    `CHK("read stop", 1'b0, rsp_refused)
    $display("t_read done");
  endtask
  task automatic t_refuse();
    do_cmd(OP_STOP, 8'h00, 1'b0);
    `CHK("stop idle", 1'b1, rsp_refused)
    do_cmd(OP_WRITE, 8'h11, 1'b0);
    `CHK("write idle", 1'b1, rsp_refused)
    do_cmd(OP_ADDR, 8'h01, 1'b0);
    `CHK("gcall read", 1'b1, rsp_refused)
    for (logic [7:0] a = 8'h78; a < 8'h80; a++)
    begin
      do_cmd(OP_ADDR, {a[6:0], 1'b0}, 1'b0);
      `CHK("reserved addr", 1'b1, rsp_refused)
    end
    `CHK("still idle", 1'b0, bus_busy)
    do_cmd(OP_ADDR, {7'h2a, 1'b0}, 1'b0);
    do_cmd(OP_STOP, 8'h00, 1'b0);
    `CHK("empty message", 1'b1, rsp_refused)
    do_cmd(OP_READ, 8'h00, 1'b0);
    `CHK("read on write", 1'b1, rsp_refused)
    do_cmd(OP_WRITE, 8'h00, 1'b0);
    `CHK("zero byte", 8'h00, rx_byte)
    do_cmd(OP_STOP, 8'h00, 1'b0);
    `CHK("stop after data", 1'b0, rsp_refused)
    $display("t_refuse done");
  endtask
  task automatic t_nack_restart();
    do_cmd(OP_ADDR, {7'h11, 1'b0}, 1'b0);
    `CHK("absent nack", 1'b1, rsp_nack)
    do_cmd(OP_WRITE, 8'h55, 1'b0);
    `CHK("write after nack", 1'b1, rsp_refused)
    do_cmd(OP_ADDR, {7'h2a, 1'b0}, 1'b0);
    `CHK("restart ack", 1'b0, rsp_nack)
    `CHK("restart busy", 1'b1, bus_busy)
    do_cmd(OP_ADDR, 8'h00, 1'b0);
    `CHK("gcall ack", 1'b0, rsp_nack)
    do_cmd(OP_WRITE, 8'h81, 1'b0);
    `CHK("gcall data", 8'h81, rx_byte)
    do_cmd(OP_STOP, 8'h00, 1'b0);
    `CHK("final stop", 1'b0, bus_busy)
    $display("t_nack_restart done");
  endtask
  task automatic t_arb();
    contend = 1'b1;
    do_cmd(OP_ADDR, {7'h2a, 1'b0}, 1'b0);
    `CHK("arb lost", 1'b1, rsp_arb_lost)
    `CHK("arb owner", 1'b0, bus_owned)
    `CHK("arb busy", 1'b1, bus_busy)
    `CHK("arb clock free", 1'b1, scl_oe_n)
    $display("t_arb done");
  endtask
  initial
  begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_ADDR;
    cmd_data = 8'h00;
    cmd_last = 1'b0;
    tx_byte = 8'h00;
    stretch_en = 1'b0;
    contend = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    `CHK("idle clock line", 1'b1, scl)
    `CHK("idle data line", 1'b1, sda)
    t_write();
    t_read();
    t_refuse();
    t_nack_restart();
    t_arb();
    test_done();
  end
endmodule // two_wire_master_tb
`default_nettype wire
